// ===== design/ptp_port0_capture_filter_lock.sv
`timescale 1ns/1ns
`include "ptp_map.svh"
// Operation
// - Alternate address 1 enable recognises 01:00:5E:00:01:82
// - Alternate address 2 enable recognises 01:00:5E:00:01:83
// - Alternate address 3 enable recognises 01:00:5E:00:01:84
// - User enable recognises the auxiliary address
// - Receive lock keeps pending receive capture
// - Transmit lock keeps pending transmit capture
// - Fabric-to-host is receive, host-to-fabric transmit
// - Pin lock keeps pending pin clock
// - Master/slave selects Sync or Delay_Req capture
// - Primary enable recognises 01:00:5E:00:01:81
module ptp_port0_capture_filter_lock (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output      logic [31:0]       prdata,
    output      logic              pready,
    output      logic              pslverr,
    input  wire logic [31:0]       ptp_clock,
    input  wire ptp_pkg::ptp_frame_s fabric_to_host,
    input  wire ptp_pkg::ptp_frame_s host_to_fabric,
    input  wire logic              pin9_capture_pulse,
    output      logic              rx_capture_pending,
    output      logic              tx_capture_pending,
    output      logic              pin9_capture_irq
);
    import ptp_pkg::*;

    ptp_apb_e    apb_state_r;
    logic [31:0] cfg_r;
    logic [15:0] aux_addr_high;
    logic [31:0] aux_addr_low;
    logic [31:0] rd_nxt;
    logic        hit_nxt;
    logic        wr_go;
    logic [2:0]  sts_clr;
    logic        rx_req;
    logic        tx_req;
    ptp_cap_s    rx_stamp;
    ptp_cap_s    tx_stamp;
    ptp_cap_s    pin_stamp;
    ptp_cap_s    rx_held;
    ptp_cap_s    tx_held;
    ptp_cap_s    pin_held;

    // Byte-lane merge of write data into an existing value
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // Destination filter shared by both directions
    function automatic logic addr_match(
        input logic [47:0] dest,
        input logic [31:0] cfg,
        input logic [47:0] aux
    );
        logic hit;
        hit = 1'b0;
        if (cfg[`PTP_BIT_PRI_EN] && dest == `PTP_ADDR_PRI) begin
            hit = 1'b1;
        end
        if (cfg[`PTP_BIT_ALT1_EN] && dest == `PTP_ADDR_ALT1) begin
            hit = 1'b1;
        end
        if (cfg[`PTP_BIT_ALT2_EN] && dest == `PTP_ADDR_ALT2) begin
            hit = 1'b1;
        end
        if (cfg[`PTP_BIT_ALT3_EN] && dest == `PTP_ADDR_ALT3) begin
            hit = 1'b1;
        end
        if (cfg[`PTP_BIT_USER_EN] && dest == aux) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Write takes effect only at the edge where pready is seen high
    assign wr_go = (apb_state_r == PTP_APB_ANS) & psel & penable & pwrite;

    // APB sequencer: one wait state, then a one-cycle answer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            apb_state_r <= PTP_APB_IDLE;
        end else begin
            case (apb_state_r)
                PTP_APB_IDLE: begin
                    if (psel && !penable) begin
                        apb_state_r <= PTP_APB_WAIT;
                    end
                end
                PTP_APB_WAIT: apb_state_r <= PTP_APB_ANS;
                PTP_APB_ANS:  apb_state_r <= PTP_APB_IDLE;
                default:      apb_state_r <= PTP_APB_IDLE;
            endcase
        end
    end

    // Read decode; unmapped offsets answer zero with an error
    always_comb begin
        rd_nxt  = 32'h0000_0000;
        hit_nxt = 1'b1;
        case (paddr)
            `PTP_OFS_CFG:     rd_nxt = cfg_r & `PTP_CFG_WMASK;
            `PTP_OFS_AUX_HI:  rd_nxt = {16'h0000, aux_addr_high};
            `PTP_OFS_AUX_LO:  rd_nxt = aux_addr_low;
            `PTP_OFS_STATUS:  rd_nxt = {29'h0, pin9_capture_irq,
                                        tx_capture_pending,
                                        rx_capture_pending};
            `PTP_OFS_RX_CLK:  rd_nxt = rx_held.clock;
            `PTP_OFS_RX_UUID: rd_nxt = rx_held.uuid[31:0];
            `PTP_OFS_RX_SEQ:  rd_nxt = {rx_held.uuid[47:32], rx_held.seq_id};
            `PTP_OFS_TX_CLK:  rd_nxt = tx_held.clock;
            `PTP_OFS_TX_UUID: rd_nxt = tx_held.uuid[31:0];
            `PTP_OFS_TX_SEQ:  rd_nxt = {tx_held.uuid[47:32], tx_held.seq_id};
            `PTP_OFS_PIN9_CLK: rd_nxt = pin_held.clock;
            default:          hit_nxt = 1'b0;
        endcase
    end

    // Answer outputs, all registered
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (apb_state_r == PTP_APB_WAIT) begin
            pready  <= 1'b1;
            pslverr <= ~hit_nxt;
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // Configuration register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg_r <= `PTP_CFG_RESET;
        end else if (wr_go && paddr == `PTP_OFS_CFG) begin
            cfg_r <= lane_merge(cfg_r, pwdata, pstrb) & `PTP_CFG_WMASK;
        end
    end

    // Auxiliary destination address
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aux_addr_high <= `PTP_AUX_HI_RESET;
            aux_addr_low  <= `PTP_AUX_LO_RESET;
        end else if (wr_go && paddr == `PTP_OFS_AUX_HI) begin
            // Upper lanes of the merge are dropped on purpose
            aux_addr_high <= 16'(lane_merge({16'h0000, aux_addr_high},
                                            pwdata, pstrb));
        end else if (wr_go && paddr == `PTP_OFS_AUX_LO) begin
            aux_addr_low <= lane_merge(aux_addr_low, pwdata, pstrb);
        end
    end

    // Write-one-to-clear on the status word, low lane only
    assign sts_clr = (wr_go && paddr == `PTP_OFS_STATUS && pstrb[0])
                   ? pwdata[2:0] : 3'h0;

    // slave captures received Sync, master Delay_Req
    assign rx_req = fabric_to_host.valid
                  & (cfg_r[`PTP_BIT_MASTER] ? fabric_to_host.is_delay_req
                                            : fabric_to_host.is_sync)
                  & addr_match(fabric_to_host.dest, cfg_r,
                               {aux_addr_high, aux_addr_low});

    // master captures sent Sync, slave Delay_Req
    assign tx_req = host_to_fabric.valid
                  & (cfg_r[`PTP_BIT_MASTER] ? host_to_fabric.is_sync
                                            : host_to_fabric.is_delay_req)
                  & addr_match(host_to_fabric.dest, cfg_r,
                               {aux_addr_high, aux_addr_low});

    // Time, identity and sequence taken together at the capture
    assign rx_stamp  = '{clock: ptp_clock, uuid: fabric_to_host.uuid,
                         seq_id: fabric_to_host.seq_id};
    assign tx_stamp  = '{clock: ptp_clock, uuid: host_to_fabric.uuid,
                         seq_id: host_to_fabric.seq_id};
    assign pin_stamp = '{clock: ptp_clock, uuid: 48'h0000_0000_0000,
                         seq_id: 16'h0000};

    // receive slot honours the receive lock
    ptp_cap_slot u_rx_slot (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cap_req (rx_req),
        .lock_en (cfg_r[`PTP_BIT_LOCK_RX]),
        .stamp   (rx_stamp),
        .clr     (sts_clr[`PTP_STS_RX]),
        .pending (rx_capture_pending),
        .held    (rx_held)
    );

    // transmit slot honours the transmit lock
    ptp_cap_slot u_tx_slot (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cap_req (tx_req),
        .lock_en (cfg_r[`PTP_BIT_LOCK_TX]),
        .stamp   (tx_stamp),
        .clr     (sts_clr[`PTP_STS_TX]),
        .pending (tx_capture_pending),
        .held    (tx_held)
    );

    // pin slot honours the pin lock
    ptp_cap_slot u_pin_slot (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cap_req (pin9_capture_pulse),
        .lock_en (cfg_r[`PTP_BIT_LOCK_PIN9]),
        .stamp   (pin_stamp),
        .clr     (sts_clr[`PTP_STS_PIN9]),
        .pending (pin9_capture_irq),
        .held    (pin_held)
    );

endmodule

// ===== design/ptp_map.svh
`ifndef PTP_MAP_SVH
`define PTP_MAP_SVH

// Register byte offsets on the APB slave
`define PTP_OFS_CFG        8'h00
`define PTP_OFS_AUX_HI     8'h04
`define PTP_OFS_AUX_LO     8'h08
`define PTP_OFS_STATUS     8'h0c
`define PTP_OFS_RX_CLK     8'h10
`define PTP_OFS_RX_UUID    8'h14
`define PTP_OFS_RX_SEQ     8'h18
`define PTP_OFS_TX_CLK     8'h1c
`define PTP_OFS_TX_UUID    8'h20
`define PTP_OFS_TX_SEQ     8'h24
`define PTP_OFS_PIN9_CLK   8'h28

// Configuration field positions
`define PTP_BIT_MASTER     15
`define PTP_BIT_PRI_EN     14
`define PTP_BIT_ALT1_EN    13
`define PTP_BIT_ALT2_EN    12
`define PTP_BIT_ALT3_EN    11
`define PTP_BIT_USER_EN    10
`define PTP_BIT_LOCK_RX    9
`define PTP_BIT_LOCK_TX    8
`define PTP_BIT_LOCK_PIN9  6

// Writable configuration bits; bit 7 and all others read as zero
`define PTP_CFG_WMASK      32'h0000_ff40
`define PTP_CFG_RESET      32'h0000_4340

// Status bit positions (write one to clear)
`define PTP_STS_RX         0
`define PTP_STS_TX         1
`define PTP_STS_PIN9       2

// Fixed multicast destinations
`define PTP_ADDR_PRI       48'h0100_5e00_0181
`define PTP_ADDR_ALT1      48'h0100_5e00_0182
`define PTP_ADDR_ALT2      48'h0100_5e00_0183
`define PTP_ADDR_ALT3      48'h0100_5e00_0184

`define PTP_AUX_HI_RESET   16'h0000
`define PTP_AUX_LO_RESET   32'h0000_0000

`endif

// ===== design/ptp_pkg.sv
package ptp_pkg;

    // One frame seen on a host-port path, valid for one cycle
    typedef struct packed {
        logic        valid;
        logic [47:0] dest;
        logic        is_sync;
        logic        is_delay_req;
        logic [47:0] uuid;
        logic [15:0] seq_id;
    } ptp_frame_s;

    // Values held by one capture slot
    typedef struct packed {
        logic [31:0] clock;
        logic [47:0] uuid;
        logic [15:0] seq_id;
    } ptp_cap_s;

    // APB answer sequencer, gray along idle -> wait -> answer
    typedef enum logic [1:0] {
        PTP_APB_IDLE = 2'b00,
        PTP_APB_WAIT = 2'b01,
        PTP_APB_ANS  = 2'b11
    } ptp_apb_e;

endpackage

// ===== design/ptp_cap_slot.sv
`timescale 1ns/1ns
// One capture slot: stored values plus its pending flag
module ptp_cap_slot (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             cap_req,
    input  wire logic             lock_en,
    input  wire ptp_pkg::ptp_cap_s stamp,
    input  wire logic             clr,
    output      logic             pending,
    output      ptp_pkg::ptp_cap_s held
);
    import ptp_pkg::*;

    logic store;

    // Lock only bites while an earlier capture is still pending
    assign store = cap_req & ~(lock_en & pending);

    // Stored values
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            held <= '0;
        end else if (store) begin
            held <= stamp;
        end
    end

    // Pending flag; a new capture wins over a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else begin
            pending <= cap_req | (pending & ~clr);
        end
    end

endmodule

// ===== testbench/ptp_port0_capture_filter_lock_properties.sv
`timescale 1ns/1ns
// Port checks: APB answer timing and sticky capture flags
module ptp_port0_capture_filter_lock_properties (
    input wire logic                sys_clk,
    input wire logic                rst_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [3:0]          pstrb,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire ptp_pkg::ptp_frame_s fabric_to_host,
    input wire ptp_pkg::ptp_frame_s host_to_fabric,
    input wire logic                pin9_capture_pulse,
    input wire logic                rx_capture_pending,
    input wire logic                tx_capture_pending,
    input wire logic                pin9_capture_irq
);
    import ptp_pkg::*;
    logic [2:0] w1c;
    // Flags that a completing status write clears in this cycle
    assign w1c = (psel && penable && pready && pwrite && pstrb[0] &&
                  paddr == 8'h0c) ? pwdata[2:0] : 3'b000;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not on second cycle after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside answer");
    chk_rx_hold: assert property (rx_capture_pending && !w1c[0]
        |=> rx_capture_pending) else $error("receive flag dropped");
    chk_tx_hold: assert property (tx_capture_pending && !w1c[1]
        |=> tx_capture_pending) else $error("transmit flag dropped");
    chk_pin_hold: assert property (pin9_capture_irq && !w1c[2]
        |=> pin9_capture_irq) else $error("pin flag dropped");
    chk_pin_set: assert property (pin9_capture_pulse
        |=> pin9_capture_irq) else $error("pin event lost");
    chk_rx_cause: assert property ($rose(rx_capture_pending)
        |-> $past(fabric_to_host.valid)) else $error("receive flag uncaused");
    chk_tx_cause: assert property ($rose(tx_capture_pending)
        |-> $past(host_to_fabric.valid)) else $error("transmit flag uncaused");
    cover property ($rose(rx_capture_pending));
    cover property ($rose(tx_capture_pending));
    cover property (pslverr);
endmodule

bind ptp_port0_capture_filter_lock ptp_port0_capture_filter_lock_properties
    i_chk (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .fabric_to_host, .host_to_fabric,
    .pin9_capture_pulse, .rx_capture_pending, .tx_capture_pending,
    .pin9_capture_irq);

// ===== testbench/ptp_frame_src.sv
`timescale 1ns/1ns
// Far side of the host port: both frame paths and the pin event
module ptp_frame_src (
    input wire logic            sys_clk,
    output ptp_pkg::ptp_frame_s fabric_to_host,
    output ptp_pkg::ptp_frame_s host_to_fabric,
    output logic                pin9_capture_pulse
);
    import ptp_pkg::*;
    localparam int FW = $bits(ptp_frame_s);
    initial begin
        fabric_to_host = '0;
        host_to_fabric = '0;
        pin9_capture_pulse = 1'b0;
    end
    // path picks direction
    // Called just after an edge; idle fields flip so stale data is not kept
    task automatic send(input int k, input ptp_frame_s f);
        if (k == 0) begin
            fabric_to_host <= f;
        end else if (k == 1) begin
            host_to_fabric <= f;
        end else begin
            pin9_capture_pulse <= 1'b1;
        end
        @(posedge sys_clk);
        fabric_to_host <= {1'b0, ~fabric_to_host[FW-2:0]};
        host_to_fabric <= {1'b0, ~host_to_fabric[FW-2:0]};
        pin9_capture_pulse <= 1'b0;
    endtask
endmodule

// ===== testbench/ptp_port0_capture_filter_lock_tb.sv
`timescale 1ns/1ns
// Random config and frames checked against a behavioural model
module ptp_port0_capture_filter_lock_tb;
    import ptp_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = '0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] ptp_clock = '0;
    ptp_frame_s  fabric_to_host;
    ptp_frame_s  host_to_fabric;
    logic        pin9_capture_pulse;
    logic        rx_capture_pending;
    logic        tx_capture_pending;
    logic        pin9_capture_irq;
    int          n_errors = 0;
    int          total_checks = 0;
    logic [31:0] cfg_m = 32'h0000_4340;
    logic [47:0] aux_m = '0;
    logic [2:0]  pend_m = '0;
    logic [31:0] clk_m [3] = '{default: '0};
    logic [47:0] uid_m [3] = '{default: '0};
    logic [15:0] seq_m [3] = '{default: '0};
    logic [47:0] fix [4] = '{48'h0100_5e00_0181, 48'h0100_5e00_0182,
                             48'h0100_5e00_0183, 48'h0100_5e00_0184};

    ptp_port0_capture_filter_lock i_dut (.sys_clk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .ptp_clock, .fabric_to_host, .host_to_fabric, .pin9_capture_pulse,
        .rx_capture_pending, .tx_capture_pending, .pin9_capture_irq);
    ptp_frame_src i_src (.sys_clk, .fabric_to_host, .host_to_fabric,
        .pin9_capture_pulse);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, x);
        check({31'h0, e}, {31'h0, xe});
    endtask

    // Send one unit and update the model as the rules say
    task automatic cap(input int k, input logic [47:0] d,
                       input logic sy, input logic dq);
        logic [31:0] c;
        logic [47:0] u;
        logic [15:0] s;
        logic        hit;
        logic        ms;
        int          lk;
        c = $urandom;
        u = {$urandom, $urandom};
        s = $urandom;
        ms = cfg_m[15];
        lk = (k == 2) ? 6 : 9 - k;
        hit = (cfg_m[14] && d === fix[0]) || (cfg_m[13] && d === fix[1]) ||
              (cfg_m[12] && d === fix[2]) || (cfg_m[11] && d === fix[3]) ||
              (cfg_m[10] && d === aux_m);
        hit = k == 2 || hit && (k == 0 ? (ms ? dq : sy) : (ms ? sy : dq));
        @(posedge sys_clk);
        ptp_clock <= c;
        i_src.send(k, '{1'b1, d, sy, dq, u, s});
        if (hit && !(pend_m[k] && cfg_m[lk])) begin
            clk_m[k] = c;
            uid_m[k] = u;
            seq_m[k] = s;
        end
        pend_m[k] = pend_m[k] | hit;
    endtask

    initial begin
        logic [31:0] v;
        logic [7:0]  a;
        int          k;
        int          sel;
        logic [3:0]  st;
        logic [31:0] m;
        void'($urandom(43));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h00, 32'h0000_4340, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        rd(8'h2c, 32'h0, 1'b1);
        wr(8'h10, 32'hffff_ffff);
        wr(8'h00, 32'hffff_ffff);
        cfg_m = 32'h0000_ff40;
        rd(8'h00, cfg_m, 1'b0);
        repeat (300) begin
            if ($urandom % 4 == 0) begin
                v = $urandom;
                // Random byte lanes so partial configuration writes are hit
                st = 4'($urandom);
                m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
                pstrb <= st;
                wr(8'h00, v);
                pstrb <= 4'hf;
                cfg_m = ((cfg_m & ~m) | (v & m)) & 32'h0000_ff40;
                rd(8'h00, cfg_m, 1'b0);
            end
            if ($urandom % 8 == 0) begin
                aux_m = {$urandom, $urandom};
                wr(8'h04, {16'h0, aux_m[47:32]});
                wr(8'h08, aux_m[31:0]);
            end
            if ($urandom % 3 == 0) begin
                v = $urandom & 32'h7;
                wr(8'h0c, v);
                pend_m = pend_m & ~v[2:0];
            end
            k = $urandom % 3;
            sel = $urandom % 6;
            cap(k, sel < 4 ? fix[sel] : sel == 4 ? aux_m
                : 48'({$urandom, $urandom}), $urandom, $urandom);
            rd(8'h0c, {29'h0, pend_m}, 1'b0);
            check({29'h0, pin9_capture_irq, tx_capture_pending,
                   rx_capture_pending}, {29'h0, pend_m});
            a = (k == 2) ? 8'h28 : 8'h10 + 8'(12 * k);
            rd(a, clk_m[k], 1'b0);
            if (k < 2) begin
                rd(a + 8'h04, uid_m[k][31:0], 1'b0);
                rd(a + 8'h08, {uid_m[k][47:32], seq_m[k]}, 1'b0);
            end
        end
        conclude();
    end
endmodule
